/* File: dmac_top.sv */
// Multiply-accumulate datapath: word products, halfword difference
// accumulates, fractional word product and halfword pack.
// Assumes the host pipeline issues at most one operation a cycle, holds an
// accumulator read request until it is answered, and owns decode.
`timescale 1ns/1ns
`include "dmac_map.svh"

module dmac_top
  import dmac_pkg::*;
#(
  parameter int LATENCY = `DMAC_MUL_LAT,
  parameter int NUM_ACC = `DMAC_NUM_ACC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        dsp_present,
  input  wire logic        dsp_enable,
  input  wire logic        issue_valid,
  input  wire dmac_op_t    issue_op,
  input  wire dmac_sel_t   sum_register_select,
  input  wire logic [31:0] src_one,
  input  wire logic [31:0] src_two,
  input  wire logic        ctrl_wr_en,
  input  wire logic [31:0] ctrl_wr_data,
  input  wire logic        acc_rd_req,
  input  wire dmac_sel_t   acc_rd_sel,
  input  wire logic        acc_rd_upper,
  output logic             exc_reserved,
  output logic             exc_disabled,
  output logic             result_valid,
  output logic      [31:0] result_word,
  output logic      [31:0] signal_proc_ctrl_reg,
  output logic             acc_rd_valid,
  output logic      [31:0] acc_rd_data,
  output logic             acc_rd_stall
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: the select field is two bits and the writeback path
  // is built from at least one register stage.
  generate
    if (NUM_ACC != 4) begin : g_bad_acc
      $error("dmac_top serves exactly four accumulators.");
    end
    if (LATENCY < 1) begin : g_bad_lat
      $error("dmac_top needs a latency of at least one cycle.");
    end
  endgenerate

  // Room for a full pipe plus one.
  localparam int PEND_W = $clog2(LATENCY + 2);
  localparam int PAY_W  = 3 + 2 + 64 + 2;

  ////////////////////////////////////////////////////////////////////////////
  // Q15 by Q15 product into Q31 with the -1 times -1 corner saturated.
  // Returns the saturation flag above the 32-bit product.
  function automatic logic [32:0] q15_product(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] prod;

    prod = $signed(a) * $signed(b);
    if (a == `DMAC_Q15_NEG_ONE && b == `DMAC_Q15_NEG_ONE) begin
      q15_product = {1'b1, `DMAC_Q31_MAX};
    end else begin
      q15_product = {1'b0, prod[30:0], 1'b0};
    end
  endfunction

  // True for operations that write an accumulator at writeback.
  function automatic logic writes_acc(input dmac_op_t op);
    writes_acc = (op == dmac_signed_word_product_op) || (op == dmac_unsigned_word_product_op) ||
                 (op == dmac_int_half_diff_accum_op) || (op == dmac_frac_half_diff_accum_sat_op);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Issue gating. A refused operation never enters the pipeline, and the
  // decision looks only at the module state, never at operand values.
  logic accept;
  assign accept = issue_valid && dsp_present && dsp_enable;

  logic exc_reserved_reg;
  logic exc_disabled_reg;

  // Reserved takes priority: an absent module cannot also be disabled.
  always_ff @(posedge clk) begin
    if (reset) begin
      exc_reserved_reg <= 1'b0;
      exc_disabled_reg <= 1'b0;
    end else begin
      exc_reserved_reg <= issue_valid && !dsp_present;
      exc_disabled_reg <= issue_valid && dsp_present && !dsp_enable;
    end
  end

  assign exc_reserved = exc_reserved_reg;
  assign exc_disabled = exc_disabled_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Operand stage: every operation forms a 64-bit contribution and its
  // saturation flags here; the pipe only delays them.
  logic [32:0]        q_upper;
  logic [32:0]        q_lower;
  logic signed [31:0] int_upper;
  logic signed [31:0] int_lower;
  logic [32:0]        int_diff;
  logic signed [63:0] word_signed;
  logic [63:0]        word_unsigned;
  logic [63:0]        frac_word;
  logic [63:0]        value_next;
  logic               sat_acc_next;
  logic               sat_word_next;

  assign q_upper       = q15_product(src_one[31:16], src_two[31:16]);
  assign q_lower       = q15_product(src_one[15:0], src_two[15:0]);
  assign int_upper     = $signed(src_one[31:16]) * $signed(src_two[31:16]);
  assign int_lower     = $signed(src_one[15:0]) * $signed(src_two[15:0]);
  assign int_diff      = {int_upper[31], int_upper} - {int_lower[31], int_lower};
  assign word_signed   = $signed(src_one) * $signed(src_two);
  assign word_unsigned = {32'h0000_0000, src_one} * {32'h0000_0000, src_two};
  assign frac_word     = {word_signed[62:0], 1'b0};

  // Only the two fractional branches raise a flag: overflow of the word products wraps silently.
  always_comb begin
    value_next    = '0;
    sat_acc_next  = 1'b0;
    sat_word_next = 1'b0;
    unique case (issue_op)
      dmac_signed_word_product_op: begin
        value_next = word_signed;
      end
      dmac_unsigned_word_product_op: begin
        value_next = word_unsigned;
      end
      dmac_int_half_diff_accum_op: begin
        value_next = {{31{int_diff[32]}}, int_diff};
      end
      dmac_frac_half_diff_accum_sat_op: begin
        value_next   = {{32{q_upper[31]}}, q_upper[31:0]} - {{32{q_lower[31]}}, q_lower[31:0]};
        sat_acc_next = q_upper[32] || q_lower[32];
      end
      dmac_frac_word_sat_product_op: begin
        if (src_one == `DMAC_Q31_NEG_ONE && src_two == `DMAC_Q31_NEG_ONE) begin
          value_next    = {`DMAC_Q31_MAX, 32'h0000_0000};
          sat_word_next = 1'b1;
        end else begin
          value_next = frac_word;
        end
      end
      dmac_halfword_pack_op: begin
        value_next = {32'h0000_0000, src_one[15:0], src_two[31:16]};
      end
      default: begin
        value_next = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writeback pipe. Ordering is kept because every operation has the same
  // latency, so back-to-back accumulates on one accumulator chain correctly.
  logic             wb_valid;
  logic [PAY_W-1:0] wb_data;
  dmac_op_t         wb_op;
  dmac_sel_t        wb_sel;
  logic [63:0]      wb_value;
  logic             wb_sat_acc;
  logic             wb_sat_word;

  dmac_pipe #(
    .WIDTH (PAY_W),
    .DEPTH (LATENCY)
  ) u_pipe (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (accept),
    .in_data   ({issue_op, sum_register_select, value_next, sat_acc_next, sat_word_next}),
    .out_valid (wb_valid),
    .out_data  (wb_data)
  );

  // Unpack in packing order.
  assign wb_op       = dmac_op_t'(wb_data[PAY_W-1 -: 3]);
  assign wb_sel      = wb_data[PAY_W-4 -: 2];
  assign wb_value    = wb_data[65:2];
  assign wb_sat_acc  = wb_data[1];
  assign wb_sat_word = wb_data[0];

  ////////////////////////////////////////////////////////////////////////////
  // Accumulators. Index zero is the base upper/bottom pair. Each one changes
  // only when it is the selected target of an accumulator-writing writeback.
  logic [31:0] upper_sum_word  [NUM_ACC];
  logic [31:0] bottom_sum_word [NUM_ACC];

  genvar i;
  generate
    for (i = 0; i < NUM_ACC; i++) begin : g_acc
      logic [63:0] acc_now;
      logic [63:0] acc_sum;

      assign acc_now = {upper_sum_word[i], bottom_sum_word[i]};
      assign acc_sum = acc_now + wb_value;

      always_ff @(posedge clk) begin
        if (reset) begin
          {upper_sum_word[i], bottom_sum_word[i]} <= `DMAC_ACC_RESET;
        end else if (wb_valid && wb_sel == 2'(i) && writes_acc(wb_op)) begin
          // The fractional word product and pack never reach this branch, so
          // accumulator zero simply keeps its value after them.
          if (wb_op == dmac_int_half_diff_accum_op || wb_op == dmac_frac_half_diff_accum_sat_op) begin
            {upper_sum_word[i], bottom_sum_word[i]} <= acc_sum;
          end else begin
            {upper_sum_word[i], bottom_sum_word[i]} <= wb_value;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Control register. The host pipeline may write it; flags from a
  // writeback in the same cycle are ORed on top, so the set always wins.
  logic [31:0] flag_set;
  logic [31:0] ctrl_reg;

  always_comb begin
    flag_set = 32'h0000_0000;
    if (wb_valid && wb_op == dmac_frac_half_diff_accum_sat_op && wb_sat_acc) begin
      flag_set[`DMAC_OUFLAG_ACC_LSB + int'(wb_sel)] = 1'b1;
    end
    if (wb_valid && wb_op == dmac_frac_word_sat_product_op && wb_sat_word) begin
      flag_set[`DMAC_OUFLAG_WORD_BIT] = 1'b1;
    end
  end

  // The integer accumulate contributes no set term at all.
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= `DMAC_CTRL_RESET;
    end else begin
      ctrl_reg <= (ctrl_wr_en ? ctrl_wr_data : ctrl_reg) | flag_set;
    end
  end

  assign signal_proc_ctrl_reg = ctrl_reg;

  ////////////////////////////////////////////////////////////////////////////
  // General-register results: fractional word product and pack.
  logic        result_valid_reg;
  logic [31:0] result_word_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      result_valid_reg <= 1'b0;
      result_word_reg  <= 32'h0000_0000;
    end else begin
      result_valid_reg <= wb_valid && !writes_acc(wb_op);
      if (wb_valid && wb_op == dmac_frac_word_sat_product_op) begin
        result_word_reg <= wb_value[63:32];
      end else if (wb_valid && wb_op == dmac_halfword_pack_op) begin
        result_word_reg <= wb_value[31:0];
      end
    end
  end

  assign result_valid = result_valid_reg;
  assign result_word  = result_word_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pending writes per accumulator. An issue and a writeback on the same
  // target in one cycle cancel, so the count never drifts.
  logic [PEND_W-1:0] pend_cnt [NUM_ACC];
  logic [NUM_ACC-1:0] pend_busy;

  generate
    for (i = 0; i < NUM_ACC; i++) begin : g_pend
      logic inc;
      logic dec;

      assign inc          = accept && writes_acc(issue_op) && sum_register_select == 2'(i);
      assign dec          = wb_valid && writes_acc(wb_op) && wb_sel == 2'(i);
      assign pend_busy[i] = (pend_cnt[i] != '0) || inc;

      always_ff @(posedge clk) begin
        if (reset) begin
          pend_cnt[i] <= '0;
        end else if (inc && !dec) begin
          pend_cnt[i] <= pend_cnt[i] + 1'b1;
        end else if (dec && !inc) begin
          pend_cnt[i] <= pend_cnt[i] - 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator reads. A read is served only once nothing is in flight for
  // that accumulator; an issue in the same cycle counts as older than the
  // read, which holds the read until that write retires but keeps program order without a compare.
  logic        rd_grant;
  logic        acc_rd_valid_reg;
  logic [31:0] acc_rd_data_reg;
  logic        acc_rd_stall_reg;

  assign rd_grant = acc_rd_req && !pend_busy[acc_rd_sel] && !acc_rd_valid_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_rd_valid_reg <= 1'b0;
      acc_rd_data_reg  <= 32'h0000_0000;
      acc_rd_stall_reg <= 1'b0;
    end else begin
      acc_rd_valid_reg <= rd_grant;
      acc_rd_stall_reg <= acc_rd_req && !rd_grant && !acc_rd_valid_reg;
      if (rd_grant) begin
        acc_rd_data_reg <= acc_rd_upper ? upper_sum_word[acc_rd_sel] : bottom_sum_word[acc_rd_sel];
      end
    end
  end

  assign acc_rd_valid = acc_rd_valid_reg;
  assign acc_rd_data  = acc_rd_data_reg;
  assign acc_rd_stall = acc_rd_stall_reg;

endmodule

/* File: dmac_map.svh */
// Constants for the signal-processing multiply-accumulate datapath.
// Assumes it is included by bare name from the package and the modules.
`ifndef DMAC_MAP_SVH
`define DMAC_MAP_SVH

// Number of accumulators, each one upper and one bottom word.
`define DMAC_NUM_ACC        4
// Cycles from issue to writeback of any operation.
`define DMAC_MUL_LAT        2
// Overflow flag positions inside the control register.
`define DMAC_OUFLAG_ACC_LSB 16
`define DMAC_OUFLAG_WORD_BIT 21
// Fractional corner values.
`define DMAC_Q15_NEG_ONE    16'h8000
`define DMAC_Q31_NEG_ONE    32'h8000_0000
`define DMAC_Q31_MAX        32'h7FFF_FFFF
// Reset values.
`define DMAC_CTRL_RESET     32'h0000_0000
`define DMAC_ACC_RESET      64'h0000_0000_0000_0000

`endif

/* File: dmac_pkg.sv */
// Types shared by the multiply-accumulate datapath and its users.
// Assumes the constant header is on the include path.
`include "dmac_map.svh"

package dmac_pkg;

  // Operations the host pipeline may issue to this datapath.
  typedef enum logic [2:0] {
    dmac_signed_word_product_op,
    dmac_unsigned_word_product_op,
    dmac_int_half_diff_accum_op,
    dmac_frac_half_diff_accum_sat_op,
    dmac_frac_word_sat_product_op,
    dmac_halfword_pack_op
  } dmac_op_t;

  // Accumulator index.
  typedef logic [1:0] dmac_sel_t;

endpackage

/* File: dmac_pipe.sv */
// Fixed-latency delay line carrying a valid bit and a payload word.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`include "dmac_map.svh"

module dmac_pipe #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `DMAC_MUL_LAT
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data
);

  ////////////////////////////////////////////////////////////////////////////
  // The logic needs at least one register stage to keep outputs on flops.
  generate
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad
      $error("dmac_pipe needs DEPTH and WIDTH of at least one.");
    end
  endgenerate

  logic             valid_reg [DEPTH];
  logic [WIDTH-1:0] data_reg  [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // One stage per generate step; reset clears both the valid bits and the data.
  genvar s;
  generate
    for (s = 0; s < DEPTH; s++) begin : g_stage
      always_ff @(posedge clk) begin
        if (reset) begin
          valid_reg[s] <= 1'b0;
          data_reg[s]  <= '0;
        end else if (s == 0) begin
          valid_reg[s] <= in_valid;
          data_reg[s]  <= in_data;
        end else begin
          valid_reg[s] <= valid_reg[s > 0 ? s-1 : 0];
          data_reg[s]  <= data_reg[s > 0 ? s-1 : 0];
        end
      end
    end
  endgenerate

  assign out_valid = valid_reg[DEPTH-1];
  assign out_data  = data_reg[DEPTH-1];

endmodule

/* File: dmac_top_asserts.sv */
// Checker for the multiply-accumulate datapath, bound to its top module.
// Assumes one clock domain and the same LATENCY as the bound instance.
`timescale 1ns/1ns
`include "dmac_map.svh"

module dmac_top_asserts
  import dmac_pkg::*;
#(
  parameter int LATENCY = `DMAC_MUL_LAT
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        dsp_present,
  input wire logic        dsp_enable,
  input wire logic        issue_valid,
  input wire dmac_op_t    issue_op,
  input wire dmac_sel_t   sum_register_select,
  input wire logic [31:0] src_one,
  input wire logic [31:0] src_two,
  input wire logic        ctrl_wr_en,
  input wire logic        acc_rd_req,
  input wire dmac_sel_t   acc_rd_sel,
  input wire logic        exc_reserved,
  input wire logic        exc_disabled,
  input wire logic        result_valid,
  input wire logic [31:0] result_word,
  input wire logic [31:0] signal_proc_ctrl_reg,
  input wire logic        acc_rd_valid,
  input wire logic        acc_rd_stall
);
  localparam int RES_DLY = LATENCY + 1;
  localparam int RD_MAX  = 16;
  ////////////////////////////////////////
  // The corner term marks a halfword pair that must saturate.
  logic        taken;
  logic        corner;
  logic [31:0] pack_val;
  assign taken    = issue_valid && dsp_present && dsp_enable;
  assign corner   = (src_one[31:16] == 16'h8000 && src_two[31:16] == 16'h8000) ||
                    (src_one[15:0] == 16'h8000 && src_two[15:0] == 16'h8000);
  assign pack_val = {src_one[15:0], src_two[31:16]};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_absent_gives_reserved: assert property (issue_valid && !dsp_present |=> exc_reserved && !exc_disabled)
    else $error("Reserved exception missing.");
  a_off_gives_disabled: assert property (issue_valid && dsp_present && !dsp_enable |=> exc_disabled)
    else $error("Disabled exception missing.");
  a_no_data_exc: assert property (taken |=> !exc_reserved && !exc_disabled)
    else $error("Exception on an accepted issue.");
  a_result_on_time: assert property (taken && issue_op >= dmac_frac_word_sat_product_op |-> ##RES_DLY result_valid)
    else $error("Result pulse late or missing.");
  a_pack_value: assert property (taken && issue_op == dmac_halfword_pack_op |->
    ##RES_DLY result_word == $past(pack_val, RES_DLY)) else $error("Pack result wrong.");
  a_sat_sets_flag: assert property (taken && issue_op == dmac_frac_half_diff_accum_sat_op && corner |->
    ##RES_DLY signal_proc_ctrl_reg[16 + $past(sum_register_select, RES_DLY)]) else $error("Saturation flag missing.");
  a_flags_only_set: assert property (!ctrl_wr_en |=> ($past(signal_proc_ctrl_reg) & ~signal_proc_ctrl_reg) == 32'h0)
    else $error("Control bit cleared without a write.");
  a_pending_stalls: assert property (taken && issue_op <= dmac_frac_half_diff_accum_sat_op && acc_rd_req &&
    !acc_rd_valid && acc_rd_sel == sum_register_select |=> acc_rd_stall && !acc_rd_valid) else $error("Read not stalled.");
  a_read_answered: assert property (acc_rd_req && !acc_rd_valid |-> ##[1:RD_MAX] acc_rd_valid)
    else $error("Read never answered.");

  c_stall_grant: cover property (acc_rd_stall ##1 acc_rd_valid);
  c_sat_issue: cover property (taken && issue_op == dmac_frac_half_diff_accum_sat_op && corner);
  c_refused: cover property (exc_reserved || exc_disabled);
endmodule

bind dmac_top dmac_top_asserts #(.LATENCY(LATENCY)) chk_u (
  .clk(clk), .reset(reset), .dsp_present(dsp_present), .dsp_enable(dsp_enable), .issue_valid(issue_valid),
  .issue_op(issue_op), .sum_register_select(sum_register_select), .src_one(src_one), .src_two(src_two),
  .ctrl_wr_en(ctrl_wr_en), .acc_rd_req(acc_rd_req), .acc_rd_sel(acc_rd_sel), .exc_reserved(exc_reserved),
  .exc_disabled(exc_disabled), .result_valid(result_valid), .result_word(result_word),
  .signal_proc_ctrl_reg(signal_proc_ctrl_reg), .acc_rd_valid(acc_rd_valid), .acc_rd_stall(acc_rd_stall)
);

/* File: dmac_host_model.sv */
// Host pipeline model: issues operations, writes control, reads accumulators.
// Assumes the bench calls one task at a time, starting at a falling edge.
`timescale 1ns/1ns

module dmac_host_model
  import dmac_pkg::*;
(
  input  wire logic        clk,
  output logic             dsp_present,
  output logic             dsp_enable,
  output logic             issue_valid,
  output dmac_op_t         issue_op,
  output dmac_sel_t        sum_register_select,
  output logic      [31:0] src_one,
  output logic      [31:0] src_two,
  output logic             ctrl_wr_en,
  output logic      [31:0] ctrl_wr_data,
  output logic             acc_rd_req,
  output dmac_sel_t        acc_rd_sel,
  output logic             acc_rd_upper,
  input  wire logic        acc_rd_valid,
  input  wire logic [31:0] acc_rd_data,
  input  wire logic        acc_rd_stall
);
  logic stall_seen;
  // Quiet values from time zero; the module starts implemented and enabled.
  initial begin
    dsp_present         = 1'b1;
    dsp_enable          = 1'b1;
    issue_valid         = 1'b0;
    issue_op            = dmac_signed_word_product_op;
    sum_register_select = 2'h0;
    src_one             = 32'h0;
    src_two             = 32'h0;
    ctrl_wr_en          = 1'b0;
    ctrl_wr_data        = 32'h0;
    acc_rd_req          = 1'b0;
    acc_rd_sel          = 2'h0;
    acc_rd_upper        = 1'b0;
    stall_seen          = 1'b0;
  end
  ////////////////////////////////////////
  // Idle operands flip every cycle, so a sample taken without a strobe shows up.
  task automatic drop();
    @(negedge clk);
    issue_valid = 1'b0;
    ctrl_wr_en  = 1'b0;
    src_one     = ~src_one;
    src_two     = ~src_two;
  endtask
  task automatic idle(input int n);
    repeat (n) drop();
  endtask
  // Back-to-back calls keep the strobe high.
  task automatic issue(input dmac_op_t op, input dmac_sel_t sel, input logic [31:0] a, input logic [31:0] b);
    @(negedge clk);
    issue_op            = op;
    sum_register_select = sel;
    src_one             = a;
    src_two             = b;
    issue_valid         = 1'b1;
  endtask
  task automatic ctrl_write(input logic [31:0] d);
    @(negedge clk);
    ctrl_wr_data = d;
    ctrl_wr_en   = 1'b1;
    drop();
  endtask
  // The request drops in the answer cycle; a quiet cycle follows.
  task automatic read_acc(input dmac_sel_t sel, input logic upper, output logic [31:0] data);
    int n;
    n            = 0;
    acc_rd_sel   = sel;
    acc_rd_upper = upper;
    acc_rd_req   = 1'b1;
    do begin
      drop();
      stall_seen = stall_seen | acc_rd_stall;
      n++;
    end while (acc_rd_valid !== 1'b1 && n < 40);
    data       = acc_rd_data;
    acc_rd_req = 1'b0;
    acc_rd_sel = ~acc_rd_sel;
    drop();
  endtask
endmodule

/* File: dsp_multiply_accumulate_tb.sv */
// Self-checking bench for the multiply-accumulate datapath.
// Assumes the host model drives every design input but clock and reset.
`timescale 1ns/1ns

module dsp_multiply_accumulate_tb;
  import dmac_pkg::*;
  localparam int LAT = 2;
  typedef struct packed {
    dmac_op_t    op;
    dmac_sel_t   sel;
    logic [31:0] a;
    logic [31:0] b;
    logic [63:0] acc;
    logic [31:0] res;
    logic [31:0] ctrl;
  } dmac_row_t;
  logic        clk = 1'b0;
  logic        reset, dsp_present, dsp_enable, issue_valid, ctrl_wr_en, acc_rd_req, acc_rd_upper;
  logic        exc_reserved, exc_disabled, result_valid, acc_rd_valid, acc_rd_stall, ac0_known;
  dmac_op_t    issue_op;
  dmac_sel_t   sum_register_select, acc_rd_sel;
  logic [31:0] src_one, src_two, ctrl_wr_data, result_word, signal_proc_ctrl_reg, acc_rd_data;
  logic [31:0] last_res = 32'h0;
  logic [63:0] snap [4];
  logic [63:0] v;
  int          fail_count = 0;
  int          n_compared = 0;
  dmac_row_t   rows [12] = '{
    '{dmac_signed_word_product_op, 2'h0, 32'hFFFF_FFFE, 32'h3, 64'hFFFF_FFFF_FFFF_FFFA, 32'h0, 32'h0},
    '{dmac_unsigned_word_product_op, 2'h1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 64'hFFFF_FFFE_0000_0001, 32'h0, 32'h0},
    '{dmac_signed_word_product_op, 2'h2, 32'h8000_0000, 32'h8000_0000, 64'h4000_0000_0000_0000, 32'h0, 32'h0},
    '{dmac_int_half_diff_accum_op, 2'h1, 32'h8000_0004, 32'h8000_FFFF, 64'hFFFF_FFFE_4000_0005, 32'h0, 32'h0},
    '{dmac_int_half_diff_accum_op, 2'h3, 32'h0001_7FFF, 32'h0001_7FFF, 64'hFFFF_FFFF_C001_0000, 32'h0, 32'h0},
    '{dmac_frac_half_diff_accum_sat_op, 2'h2, 32'h8000_4000, 32'h8000_4000, 64'h4000_0000_5FFF_FFFF, 32'h0, 32'h4_0000},
    '{dmac_frac_half_diff_accum_sat_op, 2'h3, 32'h4000_8000, 32'h2000_8000, 64'hFFFF_FFFF_5001_0001, 32'h0, 32'hC_0000},
    '{dmac_frac_half_diff_accum_sat_op, 2'h0, 32'h0001_FFFF, 32'h0003_0002, 64'h4, 32'h0, 32'hC_0000},
    '{dmac_frac_word_sat_product_op, 2'h2, 32'h4000_0000, 32'hC000_0000, 64'h0, 32'hE000_0000, 32'hC_0000},
    '{dmac_frac_word_sat_product_op, 2'h1, 32'h8000_0000, 32'h8000_0000, 64'h0, 32'h7FFF_FFFF, 32'h2C_0000},
    '{dmac_halfword_pack_op, 2'h1, 32'h1234_5678, 32'h9ABC_DEF0, 64'h0, 32'h5678_9ABC, 32'h2C_0000},
    '{dmac_unsigned_word_product_op, 2'h0, 32'h0001_0000, 32'h0001_0000, 64'h1_0000_0000, 32'h0, 32'h2C_0000}};

  dmac_top #(.LATENCY(LAT)) dut_u (
    .clk(clk), .reset(reset), .dsp_present(dsp_present), .dsp_enable(dsp_enable), .issue_valid(issue_valid),
    .issue_op(issue_op), .sum_register_select(sum_register_select), .src_one(src_one), .src_two(src_two),
    .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_data(ctrl_wr_data), .acc_rd_req(acc_rd_req), .acc_rd_sel(acc_rd_sel),
    .acc_rd_upper(acc_rd_upper), .exc_reserved(exc_reserved), .exc_disabled(exc_disabled),
    .result_valid(result_valid), .result_word(result_word), .signal_proc_ctrl_reg(signal_proc_ctrl_reg),
    .acc_rd_valid(acc_rd_valid), .acc_rd_data(acc_rd_data), .acc_rd_stall(acc_rd_stall));
  dmac_host_model host_u (
    .clk(clk), .dsp_present(dsp_present), .dsp_enable(dsp_enable), .issue_valid(issue_valid),
    .issue_op(issue_op), .sum_register_select(sum_register_select), .src_one(src_one), .src_two(src_two),
    .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_data(ctrl_wr_data), .acc_rd_req(acc_rd_req), .acc_rd_sel(acc_rd_sel),
    .acc_rd_upper(acc_rd_upper), .acc_rd_valid(acc_rd_valid), .acc_rd_data(acc_rd_data),
    .acc_rd_stall(acc_rd_stall));
  ////////////////////////////////////////
  // Clock, and a monitor that catches the one-cycle result pulse.
  always #20 clk = ~clk;
  always @(negedge clk) begin
    if (result_valid === 1'b1) last_res <= result_word;
  end
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic read64(input dmac_sel_t sel, output logic [63:0] val);
    logic [31:0] hi, lo;
    host_u.read_acc(sel, 1'b1, hi);
    host_u.read_acc(sel, 1'b0, lo);
    val = {hi, lo};
  endtask
  // Skip accumulator zero while a fractional word product left it open.
  task automatic check_accs();
    for (int j = 0; j < 4; j++) begin
      if (j != 0 || ac0_known) begin
        read64(j[1:0], v);
        check("accumulator", v, snap[j]);
      end
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Ample margin over the cycles the run needs.
  initial begin
    repeat (6000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    reset     = 1'b1;
    ac0_known = 1'b1;
    snap      = '{default: 64'h0};
    repeat (2) @(negedge clk);
    reset = 1'b0;
    foreach (rows[i]) begin
      host_u.issue(rows[i].op, rows[i].sel, rows[i].a, rows[i].b);
      host_u.idle(LAT + 2);
      if (rows[i].op >= dmac_frac_word_sat_product_op) begin
        check("result", last_res, rows[i].res);
        if (rows[i].op == dmac_frac_word_sat_product_op) ac0_known = 1'b0;
      end else begin
        snap[rows[i].sel] = rows[i].acc;
        ac0_known = ac0_known || rows[i].sel == 2'h0;
      end
      check("control", signal_proc_ctrl_reg, rows[i].ctrl);
      check_accs();
    end
    // Two writes in a row to one accumulator, with a read raised at once.
    host_u.stall_seen = 1'b0;
    host_u.issue(dmac_signed_word_product_op, 2'h1, 32'h2, 32'h3);
    host_u.issue(dmac_int_half_diff_accum_op, 2'h1, 32'h0002_0003, 32'h0004_0005);
    read64(2'h1, v);
    snap[1] = 64'hFFFF_FFFF_FFFF_FFFF;
    check("stalled read", v, snap[1]);
    check("stall seen", {63'h0, host_u.stall_seen}, 64'h1);
    // Refusals: absent, then present but off, with saturating operands.
    for (int k = 0; k < 2; k++) begin
      host_u.dsp_present = k[0];
      host_u.dsp_enable  = 1'b0;
      host_u.issue(dmac_frac_word_sat_product_op, 2'h2, 32'h8000_0000, 32'h8000_0000);
      host_u.idle(1);
      check("reserved", {63'h0, exc_reserved}, 64'(k == 0));
      check("disabled", {63'h0, exc_disabled}, 64'(k == 1));
    end
    host_u.dsp_present = 1'b1;
    host_u.dsp_enable  = 1'b1;
    host_u.idle(LAT + 2);
    check("refused result", last_res, 32'h5678_9ABC);
    host_u.ctrl_write(32'h0000_0001);
    check("control write", signal_proc_ctrl_reg, 32'h1);
    host_u.issue(dmac_frac_half_diff_accum_sat_op, 2'h0, 32'h0000_8000, 32'h0000_8000);
    host_u.idle(LAT + 2);
    snap[0] = 64'h0000_0000_8000_0001;
    check("flag of zero", signal_proc_ctrl_reg, 32'h0001_0001);
    check_accs();
    // A second reset in mid-run clears accumulators, control and pulses.
    reset = 1'b1;
    repeat (2) @(negedge clk);
    check("reset control", signal_proc_ctrl_reg, 32'h0);
    check("reset pulses", {result_valid, exc_reserved, exc_disabled, acc_rd_valid, acc_rd_stall}, 64'h0);
    reset = 1'b0;
    snap  = '{default: 64'h0};
    host_u.idle(1);
    check_accs();
    print_verdict();
  end
endmodule
